// ### pcg2_defines.vh
/*
 * Constants of the group-two peripheral clock gate: register offsets, field positions,
 * reset values and bus answer codes.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef PCG2_DEFINES_VH
`define PCG2_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PCG2_OFS_RUN_GATE      12'h108
`define PCG2_OFS_SLEEP_GATE    12'h118
`define PCG2_OFS_DEEP_GATE     12'h128
`define PCG2_OFS_CLOCK_CONFIG  12'h060
`define PCG2_OFS_IRQ_STATUS    12'h200
`define PCG2_OFS_IRQ_ENABLE    12'h204
`define PCG2_OFS_IRQ_CLEAR     12'h208

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define PCG2_BIT_PORT_A        0
`define PCG2_BIT_PORT_G        6
`define PCG2_BIT_ETH_MAC       28
`define PCG2_BIT_ETH_PHY       30
`define PCG2_BIT_AUTO_GATING   27
`define PCG2_GATE_MASK         32'h5000007f
`define PCG2_CONFIG_MASK       32'h08000000
`define PCG2_RESET_VALUE       32'h00000000
`define PCG2_ZERO_WORD         32'h00000000

// ----------------------------------------------------------------
// Avalon answer codes
// ----------------------------------------------------------------
`define PCG2_RESP_OKAY         2'h0
`define PCG2_RESP_SLAVE_ERROR  2'h2

`endif

// ### pcg2_gate_cell.v
/*
 * Clock gating cell for one peripheral unit, with the enable held from each falling edge.
 * Assumes a free-running clock; the enable comes from a flip-flop of the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module pcg2_gate_cell (
	// Clock in and enable
	input  wire clock,
	input  wire enable,
	// Gated clock out
	output wire gated_clock
);

	reg enable_hold_reg;

	// ----------------------------------------------------------------
	// Gating
	// ----------------------------------------------------------------
	// The enable is taken while the clock falls, so a change cannot cut a high phase short.
	always @(negedge clock) begin
		enable_hold_reg <= enable;
	end

	assign gated_clock = clock & enable_hold_reg;

endmodule // pcg2_gate_cell

`default_nettype wire

// ### pcg2_fault_guard.v
/*
 * Bus fault detection for accesses to unclocked units, with sticky fault status bits.
 * Assumes access strobes are one-cycle pulses synchronous to clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pcg2_defines.vh"

module pcg2_fault_guard (
	// Clock and reset
	input  wire        clock,
	input  wire        rst,
	// Unit accesses and current enables
	input  wire [31:0] unit_access,
	input  wire [31:0] unit_enable,
	// Software clear
	input  wire        clear_strobe,
	input  wire [31:0] clear_mask,
	// Results
	output reg  [31:0] fault_pulse_reg,
	output reg  [31:0] status_reg
);

	// ----------------------------------------------------------------
	// Per-unit fault and sticky status
	// ----------------------------------------------------------------
	localparam [31:0] GATE_MASK = `PCG2_GATE_MASK;

	genvar i;
	generate
		for (i = 0; i < 32; i = i + 1) begin : g_unit
			wire fault_event;
			assign fault_event = unit_access[i] & ~unit_enable[i] & GATE_MASK[i];
			always @(posedge clock) begin
				if (rst) begin
					fault_pulse_reg[i] <= 1'b0;
					status_reg[i]      <= 1'b0;
				end else begin
					fault_pulse_reg[i] <= fault_event;
					// A fault in the clearing cycle survives the clear.
					if (fault_event) begin
						status_reg[i] <= 1'b1;
					end else if (clear_strobe && clear_mask[i]) begin
						status_reg[i] <= 1'b0;
					end
				end
			end
		end
	endgenerate

endmodule // pcg2_fault_guard

`default_nettype wire

// ### pcg2_clock_gate.v
/*
 * Group-two peripheral clock gate: run, sleep and deep-sleep gating registers, mode selection,
 * glitch-free gated clocks and bus fault flags for accesses to unclocked units.
 * Assumes an Avalon-MM master with byte addresses and power state levels synchronous to clock.
 */
// The Avalon-MM slave port is this design's own decision.
// Function
// - Each gating bit is the clock enable of one unit.
// - Access to an unclocked unit answers with a bus fault.
// - All gating registers reset to zero, every unit unclocked.
// - Run, sleep or deep-sleep register chosen by operating state.
// - Sleep registers apply only when automatic gating bit is set.
// - Bits 0 to 6 enable ports A to G, read/write.
// - Bit 28 gates Ethernet MAC, bit 30 Ethernet PHY.
// - Reserved bits read zero; software preserves them on updates.
// - Run register at 0x108, sleep register at 0x118.
// - Deep-sleep register at 0x128.
`timescale 1ns/1ps
`default_nettype none
`include "pcg2_defines.vh"

module pcg2_clock_gate (
	// Clock and reset
	input  wire        clock,
	input  wire        rst,
	// Avalon-MM slave
	input  wire [11:0] avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output reg  [1:0]  avs_response,
	output reg         avs_waitrequest,
	// Power state
	input  wire        sleep_active,
	input  wire        deep_sleep_active,
	// Peripheral side
	input  wire [31:0] unit_access,
	output reg  [31:0] unit_clock_enable,
	output wire [31:0] unit_gated_clock,
	output reg  [31:0] unit_bus_fault,
	// Interrupt
	output reg         irq
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg  [31:0] run_mode_gate_group2_reg;
	reg  [31:0] sleep_mode_gate_group2_reg;
	reg  [31:0] deep_sleep_gate_group2_reg;
	reg  [31:0] run_mode_clock_config_reg;
	reg  [31:0] irq_enable_reg;
	reg  [31:0] enable_next;
	reg  [31:0] readdata_next;
	reg  [1:0]  response_next;
	reg         clear_strobe;
	wire [31:0] write_mask;
	wire [31:0] fault_pulse;
	wire [31:0] irq_status;
	wire        request;
	wire        commit;
	wire        auto_clock_gating_enable;

	assign request = avs_read | avs_write;
	// The write lands on the edge where the master sees waitrequest low.
	assign commit = request & ~avs_waitrequest;
	assign write_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
	                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign auto_clock_gating_enable = run_mode_clock_config_reg[`PCG2_BIT_AUTO_GATING];

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	// Every access takes two edges: answer prepared on the first, completed on the second.
	always @(posedge clock) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= `PCG2_ZERO_WORD;
			avs_response    <= `PCG2_RESP_OKAY;
		end else if (commit) begin
			avs_waitrequest <= 1'b1;
		end else if (request) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= readdata_next;
			avs_response    <= response_next;
		end
	end

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	always @* begin
		readdata_next = `PCG2_ZERO_WORD;
		response_next = `PCG2_RESP_OKAY;
		case (avs_address)
			`PCG2_OFS_RUN_GATE: begin
				readdata_next = run_mode_gate_group2_reg & `PCG2_GATE_MASK;
			end
			`PCG2_OFS_SLEEP_GATE: begin
				readdata_next = sleep_mode_gate_group2_reg & `PCG2_GATE_MASK;
			end
			`PCG2_OFS_DEEP_GATE: begin
				readdata_next = deep_sleep_gate_group2_reg & `PCG2_GATE_MASK;
			end
			`PCG2_OFS_CLOCK_CONFIG: begin
				readdata_next = run_mode_clock_config_reg;
			end
			`PCG2_OFS_IRQ_STATUS: begin
				readdata_next = irq_status;
			end
			`PCG2_OFS_IRQ_ENABLE: begin
				readdata_next = irq_enable_reg;
			end
			`PCG2_OFS_IRQ_CLEAR: begin
				readdata_next = `PCG2_ZERO_WORD;
			end
			default: begin
				// Unmapped offsets answer with an error so a stray pointer is noticed.
				response_next = `PCG2_RESP_SLAVE_ERROR;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always @(posedge clock) begin
		if (rst) begin
			run_mode_gate_group2_reg   <= `PCG2_RESET_VALUE;
			sleep_mode_gate_group2_reg <= `PCG2_RESET_VALUE;
			deep_sleep_gate_group2_reg <= `PCG2_RESET_VALUE;
			run_mode_clock_config_reg  <= `PCG2_RESET_VALUE;
			irq_enable_reg             <= `PCG2_RESET_VALUE;
			clear_strobe               <= 1'b0;
		end else begin
			clear_strobe <= 1'b0;
			if (commit && avs_write) begin
				case (avs_address)
					`PCG2_OFS_RUN_GATE: begin
						// Ports A..G and both Ethernet bits store; reserved bits stay zero.
						run_mode_gate_group2_reg <= ((run_mode_gate_group2_reg & ~write_mask) |
							(avs_writedata & write_mask)) & `PCG2_GATE_MASK;
					end
					`PCG2_OFS_SLEEP_GATE: begin
						sleep_mode_gate_group2_reg <= ((sleep_mode_gate_group2_reg & ~write_mask) |
							(avs_writedata & write_mask)) & `PCG2_GATE_MASK;
					end
					`PCG2_OFS_DEEP_GATE: begin
						deep_sleep_gate_group2_reg <= ((deep_sleep_gate_group2_reg & ~write_mask) |
							(avs_writedata & write_mask)) & `PCG2_GATE_MASK;
					end
					`PCG2_OFS_CLOCK_CONFIG: begin
						run_mode_clock_config_reg <= ((run_mode_clock_config_reg & ~write_mask) |
							(avs_writedata & write_mask)) & `PCG2_CONFIG_MASK;
					end
					`PCG2_OFS_IRQ_ENABLE: begin
						irq_enable_reg <= ((irq_enable_reg & ~write_mask) |
							(avs_writedata & write_mask)) & `PCG2_GATE_MASK;
					end
					`PCG2_OFS_IRQ_CLEAR: begin
						clear_strobe <= 1'b1;
					end
					default: begin
						clear_strobe <= 1'b0;
					end
				endcase
			end
		end
	end

	// The clear mask is held one cycle behind the write by the bus data being latched here.
	reg [31:0] clear_mask_reg;
	always @(posedge clock) begin
		if (rst) begin
			clear_mask_reg <= `PCG2_ZERO_WORD;
		end else if (commit && avs_write) begin
			clear_mask_reg <= avs_writedata & write_mask;
		end
	end

	// ----------------------------------------------------------------
	// Mode selection
	// ----------------------------------------------------------------
	// Without automatic gating the run register keeps ruling in low-power states.
	always @* begin
		enable_next = run_mode_gate_group2_reg;
		if (auto_clock_gating_enable && deep_sleep_active) begin
			enable_next = deep_sleep_gate_group2_reg;
		end else if (auto_clock_gating_enable && sleep_active) begin
			enable_next = sleep_mode_gate_group2_reg;
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			unit_clock_enable <= `PCG2_RESET_VALUE;
			unit_bus_fault    <= `PCG2_ZERO_WORD;
			irq               <= 1'b0;
		end else begin
			unit_clock_enable <= enable_next & `PCG2_GATE_MASK;
			unit_bus_fault    <= fault_pulse;
			irq               <= |(irq_status & irq_enable_reg);
		end
	end

	// ----------------------------------------------------------------
	// Gated clocks
	// ----------------------------------------------------------------
	genvar u;
	generate
		for (u = 0; u < 32; u = u + 1) begin : g_gate
			pcg2_gate_cell u_cell (
				.clock       (clock),
				.enable      (unit_clock_enable[u]),
				.gated_clock (unit_gated_clock[u])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Faults
	// ----------------------------------------------------------------
	// Software must enable a unit first; until then every access to port A..G or an Ethernet unit faults.
	pcg2_fault_guard u_guard (
		.clock           (clock),
		.rst             (rst),
		.unit_access     (unit_access),
		.unit_enable     (unit_clock_enable),
		.clear_strobe    (clear_strobe),
		.clear_mask      (clear_mask_reg),
		.fault_pulse_reg (fault_pulse),
		.status_reg      (irq_status)
	);

endmodule // pcg2_clock_gate

`default_nettype wire

// ### pcg2_clock_gate_chk.sv
/* Assertions for the group-two clock gate, bound to its top module.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
`include "pcg2_defines.vh"
module pcg2_clock_gate_chk (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst,
	// Bus
	input wire logic [11:0] avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic [1:0]  avs_response,
	// Units
	input wire logic [31:0] unit_access,
	input wire logic [31:0] unit_clock_enable,
	input wire logic [31:0] unit_gated_clock,
	input wire logic [31:0] unit_bus_fault,
	input wire logic        irq
);
	wire        mapped = avs_address inside {12'h108, 12'h118, 12'h128, 12'h060, 12'h200, 12'h204, 12'h208};
	wire [31:0] cause  = unit_access & ~unit_clock_enable & `PCG2_GATE_MASK;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not after one wait cycle");
	idle_wait_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("bus answered with no request");
	resp_code_a: assert property ((avs_read || avs_write) && !avs_waitrequest |-> avs_response == (mapped ? 2'h0 : 2'h2))
		else $error("wrong bus response code");
	fault_raise_a: assert property (|cause |-> ##2 (unit_bus_fault & $past(cause, 2)) == $past(cause, 2))
		else $error("access to unclocked unit gave no fault");
	fault_cause_a: assert property (|unit_bus_fault |-> unit_bus_fault == $past(cause, 2))
		else $error("fault without access to unclocked unit");
	reserved_zero_a: assert property ((unit_clock_enable & ~`PCG2_GATE_MASK) == 32'h0)
		else $error("reserved unit enable set");
	reset_clear_a: assert property ($fell(rst) |-> unit_clock_enable == 32'h0 && avs_waitrequest && !irq)
		else $error("state not cleared by reset");
	irq_sticky_a: assert property ((irq && !avs_write)[*3] |=> irq)
		else $error("interrupt dropped without a write");
	// Sampled on the falling edge, so the high phase shows the latched enable.
	gated_clock_a: assert property (@(negedge clock) disable iff (rst) unit_gated_clock == $past(unit_clock_enable))
		else $error("gated clock does not follow enable");
	cover property (|unit_bus_fault);
	cover property ($rose(irq));
	cover property (avs_read && !avs_waitrequest && !mapped);
endmodule // pcg2_clock_gate_chk
bind pcg2_clock_gate pcg2_clock_gate_chk u_chk (.clock(clock), .rst(rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
	.unit_access(unit_access), .unit_clock_enable(unit_clock_enable), .unit_gated_clock(unit_gated_clock),
	.unit_bus_fault(unit_bus_fault), .irq(irq));
`default_nettype wire

// ### pcg2_clock_gate_tb.sv
/* Self-checking bench of the group-two clock gate.
   Assumes the checker file is compiled beside it. */
`timescale 1ns/1ps
`default_nettype none
`include "pcg2_defines.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module pcg2_clock_gate_tb;
	logic        clock = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic        sleep_active = 1'b0, deep_sleep_active = 1'b0;
	logic [11:0] avs_address = 12'h0;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] avs_writedata = 32'h0, unit_access = 32'h0, rdat;
	logic [1:0]  rresp;
	wire  [31:0] avs_readdata, unit_clock_enable, unit_gated_clock, unit_bus_fault;
	wire  [1:0]  avs_response;
	wire         avs_waitrequest, irq;
	int          error_cnt = 0, cmp_count = 0, cyc = 0, i;
	typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] r; logic [1:0] s;} pcg2_row_t;
	pcg2_row_t rows [10] = '{'{12'h108, 32'hffffffff, 32'h5000007f, 2'h0}, '{12'h118, 32'hffffffff, 32'h5000007f, 2'h0},
		'{12'h128, 32'hffffffff, 32'h5000007f, 2'h0}, '{12'h060, 32'hffffffff, 32'h08000000, 2'h0},
		'{12'h060, 32'h0, 32'h0, 2'h0}, '{12'h10c, 32'hffffffff, 32'h0, 2'h2},
		'{12'h200, 32'hffffffff, 32'h0, 2'h0}, '{12'h204, 32'hffffffff, 32'h5000007f, 2'h0},
		'{12'h208, 32'hffffffff, 32'h0, 2'h0}, '{12'h108, 32'h0, 32'h0, 2'h0}};
	always #4 clock = ~clock;
	pcg2_clock_gate dut (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_response(avs_response), .avs_waitrequest(avs_waitrequest), .sleep_active(sleep_active),
		.deep_sleep_active(deep_sleep_active), .unit_access(unit_access), .unit_clock_enable(unit_clock_enable),
		.unit_gated_clock(unit_gated_clock), .unit_bus_fault(unit_bus_fault), .irq(irq));
	// ----------------------------------------------------------------
	// Bus and run control
	// ----------------------------------------------------------------
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		rdat = avs_readdata;
		rresp = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task rdchk(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK("read data", e, rdat)
	endtask
	// Ends in the low phase after the fault pulse has been launched, while it stands.
	task hit(input logic [31:0] m);
		@(posedge clock);
		unit_access <= m;
		@(posedge clock);
		unit_access <= 32'h0;
		@(posedge clock);
		@(negedge clock);
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			$display("ERROR timeout expected end seen hang");
			final_report;
		end
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		rdchk(12'h108, 32'h0);
		rdchk(12'h118, 32'h0);
		rdchk(12'h128, 32'h0);
		`CHK("enable after reset", 32'h0, unit_clock_enable)
		$display("test reset done");
		for (i = 0; i < 10; i++) begin
			bus(1'b1, rows[i].a, rows[i].d);
			`CHK("write response", rows[i].s, rresp)
			rdchk(rows[i].a, rows[i].r);
			`CHK("read response", rows[i].s, rresp)
			repeat (3) @(posedge clock);
			if (rows[i].a == `PCG2_OFS_RUN_GATE)
				`CHK("unit enable", rows[i].r, unit_clock_enable)
		end
		$display("test register rows done");
		bus(1'b1, 12'h108, 32'h1);
		bus(1'b1, 12'h118, 32'h2);
		bus(1'b1, 12'h128, 32'h4);
		sleep_active <= 1'b1;
		repeat (3) @(posedge clock);
		`CHK("sleep without auto gating", 32'h1, unit_clock_enable)
		bus(1'b1, 12'h060, 32'h08000000);
		for (i = 0; i < 4; i++) begin
			sleep_active <= i[0];
			deep_sleep_active <= i[1];
			repeat (3) @(posedge clock);
			`CHK("mode enable", i[1] ? 32'h4 : (i[0] ? 32'h2 : 32'h1), unit_clock_enable)
		end
		sleep_active <= 1'b0;
		deep_sleep_active <= 1'b0;
		$display("test modes done");
		bus(1'b1, 12'h108, 32'h40000000);
		repeat (3) @(posedge clock);
		#2;
		`CHK("gated clock", 2'h2, {unit_gated_clock[30], unit_gated_clock[0]})
		bus(1'b1, 12'h204, 32'h5000007f);
		hit(32'h1);
		`CHK("fault pulse", 32'h1, unit_bus_fault)
		`CHK("irq raised", 1'b1, irq)
		hit(32'h40000000);
		`CHK("no fault when clocked", 32'h0, unit_bus_fault)
		rdchk(12'h200, 32'h1);
		bus(1'b1, 12'h208, 32'h1);
		rdchk(12'h200, 32'h0);
		rdchk(12'h208, 32'h0);
		`CHK("irq cleared", 1'b0, irq)
		bus(1'b1, 12'h204, 32'h0);
		hit(32'h10000000);
		`CHK("mac fault pulse", 32'h10000000, unit_bus_fault)
		repeat (2) @(posedge clock);
		rdchk(12'h200, 32'h10000000);
		`CHK("masked irq", 1'b0, irq)
		$display("test faults done");
		// Only the top lane is written, so ports A..G stay off while the MAC bit joins the PHY bit.
		avs_byteenable <= 4'h8;
		bus(1'b1, 12'h108, 32'hffffffff);
		avs_byteenable <= 4'hf;
		rdchk(12'h108, 32'h50000000);
		$display("test byte lanes done");
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		`CHK("enable after second reset", 32'h0, unit_clock_enable)
		rdchk(12'h108, 32'h0);
		rdchk(12'h200, 32'h0);
		$display("test second reset done");
		final_report;
	end
endmodule // pcg2_clock_gate_tb
`default_nettype wire
